//--- logic/flash_host_pkg.sv
// Package with constants and types shared by the flash host controller.
package flash_host_pkg;
    // Bus widths of the device pins.
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    // Bit positions of the status bits shown during an embedded operation.
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;
    // Bus cycle timing at 200 MHz (5 ns clock period).
    localparam int CLK_PERIOD_NS = 5;
    localparam int RANDOM_ACCESS_NS = 70;
    localparam int PAGE_ACCESS_NS = 30;
    localparam int WRITE_PULSE_NS = 35;
    localparam int RESTORE_PULSE_NS = 500;
    localparam int RANDOM_CYC =
        (RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_CYC =
        (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC =
        (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTORE_CYC =
        (RESTORE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = 2;
    localparam int CNT_W = 8;
    // Page geometry: eight words per page.
    localparam int PAGE_W = 3;
    // Standard unlock addresses and command codes.
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h0002AA;
    localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 16'h00AA;
    localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 16'h0055;
    localparam logic [DATA_W-1:0] CODE_PROGRAM = 16'h00A0;
    localparam logic [DATA_W-1:0] CODE_ERASE = 16'h0080;
    localparam logic [DATA_W-1:0] CODE_SECTOR = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_BYPASS = 16'h0020;
    localparam logic [DATA_W-1:0] CODE_BYP_EX1 = 16'h0090;
    localparam logic [DATA_W-1:0] CODE_BYP_EX2 = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_SUSPEND = 16'h00B0;
    localparam logic [DATA_W-1:0] CODE_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_RESET = 16'h00F0;
    localparam logic [DATA_W-1:0] CODE_OTP_ENTER = 16'h0088;
    localparam logic [DATA_W-1:0] CODE_OTP_EXIT = 16'h0090;
    localparam logic [DATA_W-1:0] CODE_OTP_EXIT2 = 16'h0000;
    // User operations.
    typedef enum logic [3:0] {
        OP_READ, OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_RESUME,
        OP_BYPASS_ON, OP_BYPASS_OFF, OP_OTP_ENTER, OP_OTP_EXIT,
        OP_RESET, OP_RESTORE
    } op_e;
endpackage

//--- logic/flash_bus_cycle.sv
// One read or write cycle on the flash pins, timed in clock cycles.
`timescale 1ns/1ps
module flash_bus_cycle (
    // Clock and reset.
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    // Cycle request.
    input  wire logic                              start,
    input  wire logic                              is_write,
    input  wire logic                              fast,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] addr,
    input  wire logic [flash_host_pkg::DATA_W-1:0] wdata,
    output logic                                   busy,
    output logic                                   done,
    output logic [flash_host_pkg::DATA_W-1:0]      rdata,
    // Synchronised read data from the pins.
    input  wire logic [flash_host_pkg::DATA_W-1:0] pin_din,
    // Device pins.
    output logic                                   chip_sel_n,
    output logic                                   write_n,
    output logic                                   out_en_n,
    output logic [flash_host_pkg::ADDR_W-1:0]      addr_out,
    output logic [flash_host_pkg::DATA_W-1:0]      data_out,
    output logic                                   data_oe
);
    import flash_host_pkg::*;

    typedef enum logic [1:0] {C_IDLE, C_ACT, C_GAP} cyc_e;
    cyc_e             state;
    logic [CNT_W-1:0] cnt;
    logic             wr;

    // Access length: reads wait the random or page time, writes the pulse.
    // Three extra cycles cover the input synchroniser on the read path.
    wire [CNT_W-1:0] act_len = is_write ? CNT_W'(WRITE_CYC)
        : fast ? CNT_W'(PAGE_CYC + 3) : CNT_W'(RANDOM_CYC + 3);
    wire in_act = (state == C_ACT);

    assign busy = (state != C_IDLE);
    // Strobes stay off when idle: a deselected device sits in standby.
    assign chip_sel_n = !in_act;
    assign write_n    = !(in_act && wr);
    assign out_en_n   = !(in_act && !wr);
    assign data_oe    = in_act && wr;

    // Cycle sequencer; a gap separates cycles so the device sees edges.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= C_IDLE;
            cnt      <= '0;
            wr       <= 1'b0;
            done     <= 1'b0;
            rdata    <= '0;
            addr_out <= '0;
            data_out <= '0;
        end else begin
            done <= 1'b0;
            unique case (state)
                C_IDLE: if (start) begin
                    state    <= C_ACT;
                    cnt      <= act_len;
                    wr       <= is_write;
                    addr_out <= addr;
                    data_out <= wdata;
                end
                C_ACT: if (cnt == CNT_W'(1)) begin
                    state <= C_GAP;
                    cnt   <= CNT_W'(GAP_CYC);
                    if (!wr) begin
                        rdata <= pin_din;
                    end
                end else begin
                    cnt <= cnt - CNT_W'(1);
                end
                C_GAP: if (cnt == CNT_W'(1)) begin
                    state <= C_IDLE;
                    done  <= 1'b1;
                end else begin
                    cnt <= cnt - CNT_W'(1);
                end
            endcase
        end
    end
endmodule

//--- logic/flash_host.sv
// Host controller that drives the banked page flash through its pins.
`timescale 1ns/1ps
module flash_host (
    // Clock and reset.
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    // User command port.
    input  wire logic                              req_valid,
    output logic                                   req_ready,
    input  wire flash_host_pkg::op_e               req_op,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [flash_host_pkg::DATA_W-1:0] req_data,
    input  wire logic                              lock_guard_on,
    // User answer port.
    output logic                                   resp_valid,
    output logic [flash_host_pkg::DATA_W-1:0]      resp_data,
    output logic                                   op_busy,
    output logic                                   bypass_mode,
    output logic                                   erase_held,
    // Device pins.
    output logic                                   chip_sel_n,
    output logic                                   write_n,
    output logic                                   out_en_n,
    output logic                                   restore_n,
    output logic                                   lock_guard_n,
    output logic [flash_host_pkg::ADDR_W-1:0]      addr_out,
    input  wire logic [flash_host_pkg::DATA_W-1:0] word_data_lines_in,
    output logic [flash_host_pkg::DATA_W-1:0]      word_data_lines_out,
    output logic                                   word_data_lines_oe,
    input  wire logic                              done_indicator_pin
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_SEQ, S_WAIT, S_READ, S_RESTORE
    } host_e;

    // Reset release through two flip-flops.
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Three-stage input synchronisers; a change counts when stages 2 and 3
    // agree, so a half-settled bus word is never taken.
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic [DATA_W-1:0] din_s3;
    logic [DATA_W-1:0] din;
    logic [2:0]        rdy_s;
    logic              rdy;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            din_s1 <= '0;
            din_s2 <= '0;
            din_s3 <= '0;
            din    <= '0;
            rdy_s  <= 3'h7;
            rdy    <= 1'b1;
        end else begin
            din_s1 <= word_data_lines_in;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
            rdy_s  <= {rdy_s[1:0], done_indicator_pin};
            if (din_s2 == din_s3) begin
                din <= din_s3;
            end
            if (rdy_s[1] == rdy_s[2]) begin
                rdy <= rdy_s[2];
            end
        end
    end

    // Controller state.
    host_e             state;
    op_e               op;
    logic [ADDR_W-1:0] op_addr;
    logic [DATA_W-1:0] op_data;
    logic [2:0]        step;
    logic [2:0]        nsteps;
    logic [CNT_W-1:0]  rcnt;
    logic [DATA_W-1:0] last_status;
    logic              have_status;
    logic [ADDR_W-PAGE_W-1:0] open_page;
    logic              page_open;

    // Bus cycle engine signals.
    logic              cyc_start;
    logic              cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_wdata;
    logic              cyc_busy;
    logic              cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic              cyc_oe;

    // Number of write cycles for each operation.
    function automatic logic [2:0] seq_len(input op_e o, input logic byp);
        unique case (o)
            OP_PROGRAM:    seq_len = byp ? 3'h2 : 3'h4;
            OP_ERASE:      seq_len = 3'h6;
            OP_BYPASS_ON:  seq_len = 3'h3;
            OP_BYPASS_OFF: seq_len = 3'h2;
            OP_OTP_ENTER:  seq_len = 3'h3;
            OP_OTP_EXIT:   seq_len = 3'h4;
            default:       seq_len = 3'h1;
        endcase
    endfunction

    // Address and data of write cycle k of an operation.
    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
        input op_e o, input logic byp, input logic [2:0] k,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [ADDR_W-1:0] wa;
        logic [DATA_W-1:0] wd;
        wa = (k[0] == 1'b0) ? UNLOCK_A1 : UNLOCK_A2;
        wd = (k[0] == 1'b0) ? CODE_UNLOCK1 : CODE_UNLOCK2;
        unique case (o)
            OP_PROGRAM: if (byp) begin
                wa = (k == 3'h0) ? a : a;
                wd = (k == 3'h0) ? CODE_PROGRAM : d;
            end else if (k == 3'h2) begin
                wa = UNLOCK_A1;
                wd = CODE_PROGRAM;
            end else if (k == 3'h3) begin
                wa = a;
                wd = d;
            end
            OP_ERASE: if (k == 3'h2) begin
                wd = CODE_ERASE;
            end else if (k == 3'h5) begin
                wa = a;
                wd = CODE_SECTOR;
            end
            OP_BYPASS_ON: if (k == 3'h2) wd = CODE_BYPASS;
            OP_BYPASS_OFF: begin
                wa = a;
                wd = (k == 3'h0) ? CODE_BYP_EX1 : CODE_BYP_EX2;
            end
            OP_OTP_ENTER: if (k == 3'h2) wd = CODE_OTP_ENTER;
            OP_OTP_EXIT: if (k == 3'h2) begin
                wd = CODE_OTP_EXIT;
            end else if (k == 3'h3) begin
                wd = CODE_OTP_EXIT2;
            end
            OP_SUSPEND: begin
                wa = a;
                wd = CODE_SUSPEND;
            end
            OP_RESUME: begin
                wa = a;
                wd = CODE_RESUME;
            end
            default: wd = CODE_RESET;
        endcase
        seq_word = {wa, wd};
    endfunction

    wire [ADDR_W+DATA_W-1:0] word_now =
        seq_word(op, bypass_mode, step, op_addr, op_data);
    wire is_embedded = (op == OP_PROGRAM) || (op == OP_ERASE) ||
        (op == OP_RESUME);
    // Toggling bit 6 between two status reads means still running.
    wire toggled = have_status &&
        (last_status[TOGGLE_BIT] != cyc_rdata[TOGGLE_BIT]);
    // Polarity bit equal to the written data means a program finished.
    wire poll_ok = (cyc_rdata[POLL_BIT] == op_data[POLL_BIT]);
    wire finished = !toggled && ((op != OP_PROGRAM) || poll_ok) && rdy;
    // Reads stay in an open page are timed short.
    wire same_page = page_open &&
        (open_page == req_addr[ADDR_W-1:PAGE_W]);
    wire take = req_valid && req_ready;

    assign req_ready = (state == S_IDLE);
    assign op_busy = (state == S_WAIT);
    assign cyc_start = (state == S_SEQ || state == S_WAIT ||
        state == S_READ) && !cyc_busy && !cyc_done;
    assign cyc_write = (state == S_SEQ);
    assign cyc_addr = (state == S_SEQ) ? word_now[ADDR_W+DATA_W-1:DATA_W]
        : op_addr;
    assign cyc_wdata = word_now[DATA_W-1:0];
    assign lock_guard_n = !lock_guard_on;
    assign word_data_lines_oe = cyc_oe;

    // Operation sequencer: issues writes, then polls status to completion.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state       <= S_IDLE;
            op          <= OP_READ;
            op_addr     <= '0;
            op_data     <= '0;
            step        <= '0;
            nsteps      <= '0;
            rcnt        <= '0;
            last_status <= '0;
            have_status <= 1'b0;
            resp_valid  <= 1'b0;
            resp_data   <= '0;
            bypass_mode <= 1'b0;
            erase_held  <= 1'b0;
            restore_n   <= 1'b1;
            open_page   <= '0;
            page_open   <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            unique case (state)
                S_IDLE: if (take) begin
                    op          <= req_op;
                    op_addr     <= req_addr;
                    op_data     <= req_data;
                    step        <= '0;
                    nsteps      <= seq_len(req_op, bypass_mode);
                    have_status <= 1'b0;
                    if (req_op == OP_RESTORE) begin
                        state     <= S_RESTORE;
                        rcnt      <= CNT_W'(RESTORE_CYC);
                        restore_n <= 1'b0;
                    end else if (req_op == OP_READ) begin
                        state <= S_READ;
                    end else begin
                        state <= S_SEQ;
                        page_open <= 1'b0;
                    end
                end
                S_SEQ: if (cyc_done) begin
                    if (step == nsteps - 3'h1) begin
                        state <= is_embedded ? S_WAIT : S_IDLE;
                        resp_valid <= !is_embedded;
                        if (op == OP_BYPASS_ON) bypass_mode <= 1'b1;
                        if (op == OP_BYPASS_OFF || op == OP_RESET)
                            bypass_mode <= 1'b0;
                        if (op == OP_SUSPEND) erase_held <= 1'b1;
                        if (op == OP_RESUME) erase_held <= 1'b0;
                    end else begin
                        step <= step + 3'h1;
                    end
                end
                S_WAIT: if (cyc_done) begin
                    last_status <= cyc_rdata;
                    have_status <= 1'b1;
                    if (finished) begin
                        state      <= S_IDLE;
                        resp_valid <= 1'b1;
                        resp_data  <= cyc_rdata;
                    end
                end
                S_READ: if (cyc_done) begin
                    state      <= S_IDLE;
                    resp_valid <= 1'b1;
                    resp_data  <= cyc_rdata;
                    open_page  <= op_addr[ADDR_W-1:PAGE_W];
                    page_open  <= 1'b1;
                end
                S_RESTORE: if (rcnt == CNT_W'(1)) begin
                    restore_n   <= 1'b1;
                    state       <= S_IDLE;
                    resp_valid  <= 1'b1;
                    bypass_mode <= 1'b0;
                    erase_held  <= 1'b0;
                    page_open   <= 1'b0;
                end else begin
                    rcnt <= rcnt - CNT_W'(1);
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Fast timing is chosen when the read stays within the open page.
    logic fast_read;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fast_read <= 1'b0;
        end else if (take) begin
            fast_read <= same_page && req_op == OP_READ;
        end
    end

    flash_bus_cycle u_cycle (
        .clock      (clock),
        .rst_n      (rst_sync_n),
        .start      (cyc_start),
        .is_write   (cyc_write),
        .fast       (fast_read && state == S_READ),
        .addr       (cyc_addr),
        .wdata      (cyc_wdata),
        .busy       (cyc_busy),
        .done       (cyc_done),
        .rdata      (cyc_rdata),
        .pin_din    (din),
        .chip_sel_n (chip_sel_n),
        .write_n    (write_n),
        .out_en_n   (out_en_n),
        .addr_out   (addr_out),
        .data_out   (word_data_lines_out),
        .data_oe    (cyc_oe)
    );
endmodule

//--- verification/flash_host_monitor.sv
// Checker of pin timing and handshake of the flash host controller.
`timescale 1ns/1ps
module flash_host_monitor (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // User side and strobes.
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic op_busy,
    input wire logic lock_guard_on,
    input wire logic chip_sel_n,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic restore_n,
    input wire logic lock_guard_n,
    input wire logic word_data_lines_oe,
    // Address and data pins.
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_out,
    input wire logic [flash_host_pkg::DATA_W-1:0] word_data_lines_out
);
    import flash_host_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Restore pulse length; a short pulse may leave the device half reset.
    logic [CNT_W-1:0] low_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            low_cnt <= '0;
        else
            low_cnt <= restore_n ? '0 : low_cnt + 1'b1;
    end
    // Pin and handshake relations.
    property p_no_clash;
        !(word_data_lines_oe && !out_en_n) && (write_n || out_en_n);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("data lines driven during read");
    property p_wr_pulse;
        $fell(write_n) |-> !write_n [*7] ##1 write_n;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write pulse length wrong");
    property p_wr_hold;
        !write_n && $past(!write_n) |-> $stable(addr_out) &&
            $stable(word_data_lines_out) && word_data_lines_oe && !chip_sel_n;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write address or data moved");
    property p_rd_hold;
        $fell(out_en_n) |=> (!out_en_n && $stable(addr_out)) [*8];
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read cycle cut short");
    property p_resp;
        resp_valid |=> !resp_valid;
    endproperty
    a_resp: assert property (p_resp)
        else $error("answer longer than one cycle");
    property p_restore;
        $rose(restore_n) |-> low_cnt == RESTORE_CYC;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore pulse length wrong");
    property p_guard;
        lock_guard_n == !lock_guard_on;
    endproperty
    a_guard: assert property (p_guard)
        else $error("guard pin wrong");
    property p_busy;
        op_busy |-> !req_ready && write_n;
    endproperty
    a_busy: assert property (p_busy)
        else $error("request open while busy");
    c_write: cover property ($fell(write_n));
    c_poll: cover property (op_busy ##1 !op_busy);
    c_restore: cover property ($rose(restore_n));
endmodule

//--- verification/flash_dev_model.sv
// Behavioural model of the banked page flash as seen at its pins.
`timescale 1ns/1ps
module flash_dev_model (
    // Clock and answer speed.
    input wire logic clock,
    input wire logic slow,
    // Strobes from the host.
    input wire logic chip_sel_n,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic restore_n,
    input wire logic lock_guard_n,
    // Address and data.
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_in,
    output logic     [flash_host_pkg::DATA_W-1:0] data_out,
    output logic                                  ready
);
    import flash_host_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] h0, h1, h2, lat_d, stat;
    logic [ADDR_W-1:0] lat_a, op_a;
    logic              byp = 0, prog = 0, held = 0, tog = 0;
    logic              wr_q = 1, rd_q = 1;
    int                busy = 0;
    // Outer 8Kw sectors at either end are guarded; a held erase is ready.
    wire guard = !lock_guard_n && (lat_a[22:13] == '0 || &lat_a[22:13]);
    wire hit = busy > 0 && addr_in[22:21] == op_a[22:21];
    assign ready = busy == 0 || held;
    initial data_out = '0;
    // Commands act at the end of a write, on the latched address and data.
    always @(posedge clock) begin
        wr_q <= write_n || chip_sel_n;
        if (!write_n && !chip_sel_n) begin
            lat_a <= addr_in;
            lat_d <= data_in;
        end
        if (busy > 0 && !held) busy <= busy - 1;
        if (!restore_n) begin
            busy <= 0;
            byp <= 0;
            prog <= 0;
            held <= 0;
        end else if (!wr_q && (write_n || chip_sel_n)) begin
            {h2, h1, h0} <= {h1, h0, lat_d};
            if (prog) begin
                prog <= 0;
                if (!guard) begin
                    mem[lat_a] = lat_d & (mem.exists(lat_a) ? mem[lat_a] : '1);
                    {op_a, stat} <= {lat_a, ~lat_d};
                    busy <= slow ? 40 : 3;
                end
            end else if (lat_d == CODE_SUSPEND && busy > 0) held <= 1;
            else if (lat_d == CODE_RESUME && held) held <= 0;
            else if (lat_d == CODE_PROGRAM && (byp || h0 == CODE_UNLOCK2))
                prog <= 1;
            else if (lat_d == CODE_BYPASS && h0 == CODE_UNLOCK2) byp <= 1;
            else if (lat_d == CODE_BYP_EX2 && h0 == CODE_BYP_EX1) byp <= 0;
            else if (lat_d == CODE_SECTOR && h2 == CODE_ERASE && !guard) begin
                foreach (mem[k]) if (k[22:15] == lat_a[22:15]) mem[k] = '1;
                {op_a, stat} <= {lat_a, 16'h0000};
                busy <= slow ? 40 : 3;
            end
        end
    end
    // Released lines flip every cycle so a late sample cannot match by luck.
    always @(posedge clock) begin
        rd_q <= out_en_n || chip_sel_n;
        if (rd_q && !(out_en_n || chip_sel_n) && busy > 0) tog <= !tog;
        if (out_en_n || chip_sel_n) data_out <= ~data_out;
        else if (hit) data_out <= {stat[15:7], tog, stat[5:0]};
        else data_out <= mem.exists(addr_in) ? mem[addr_in] : '1;
    end
endmodule

//--- verification/flash_host_test.sv
// Self-checking bench: flash host controller driving a device model.
`timescale 1ns/1ps
module flash_host_test;
    import flash_host_pkg::*;
    logic              clock = 0, rst_n = 0, req_valid = 0;
    logic              lock_guard_on = 0, slow = 0;
    op_e               req_op = OP_READ;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_data = '0, got;
    int                mismatches = 0, num_checks = 0, cycles = 0;
    wire logic req_ready, resp_valid, op_busy, bypass_mode, erase_held;
    wire logic chip_sel_n, write_n, out_en_n, restore_n, lock_guard_n;
    wire logic word_data_lines_oe, done_indicator_pin;
    wire logic [ADDR_W-1:0] addr_out;
    wire logic [DATA_W-1:0] word_data_lines_out, resp_data, dev_q;
    // The host sees its own word while driving, else the device's.
    wire logic [DATA_W-1:0] word_data_lines_in =
        word_data_lines_oe ? word_data_lines_out : dev_q;
    flash_host dut_u (
        .clock, .rst_n, .req_valid, .req_ready, .req_op, .req_addr,
        .req_data, .lock_guard_on, .resp_valid, .resp_data, .op_busy,
        .bypass_mode, .erase_held, .chip_sel_n, .write_n, .out_en_n,
        .restore_n, .lock_guard_n, .addr_out, .word_data_lines_in,
        .word_data_lines_out, .word_data_lines_oe, .done_indicator_pin);
    flash_dev_model dev_u (
        .clock, .slow, .chip_sel_n, .write_n, .out_en_n, .restore_n,
        .lock_guard_n, .addr_in(addr_out), .data_in(word_data_lines_in),
        .data_out(dev_q), .ready(done_indicator_pin));
    // Clock, and a ceiling so a hung handshake still ends with a verdict.
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(string what, logic [DATA_W-1:0] exp, seen);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Offer one request, wait until taken, then wait for its answer.
    task automatic run(op_e op, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge clock);
        req_op = op;
        {req_addr, req_data, req_valid} = {a, d, 1'b1};
        while (req_ready !== 1'b1 && n++ < 500) @(negedge clock);
        @(negedge clock);
        req_valid = 0;
        while (resp_valid !== 1'b1 && n++ < 9000) @(negedge clock);
        got = resp_data;
        check("answer", 16'h0001, {15'h0, resp_valid});
    endtask
    // Four-write program polled to completion, then read back.
    task automatic t_program();
        run(OP_PROGRAM, 23'h400010, 16'h1234);
        check("program status", 16'h1234, got);
        run(OP_READ, 23'h400010, 16'h0000);
        check("read back", 16'h1234, got);
    endtask
    // Bypass program against a slow device, then an in-page read.
    task automatic t_bypass();
        slow = 1;
        run(OP_BYPASS_ON, 23'h000000, 16'h0000);
        check("bypass on", 16'h0001, {15'h0, bypass_mode});
        run(OP_PROGRAM, 23'h400011, 16'h00C3);
        check("bypass status", 16'h00C3, got);
        run(OP_READ, 23'h400010, 16'h0000);
        run(OP_READ, 23'h400011, 16'h0000);
        check("page word", 16'h00C3, got);
        run(OP_BYPASS_OFF, 23'h000000, 16'h0000);
        check("bypass off", 16'h0000, {15'h0, bypass_mode});
        slow = 0;
    endtask
    // Sector erase clears its own sector and spares another.
    task automatic t_erase();
        run(OP_PROGRAM, 23'h600000, 16'h5A5A);
        run(OP_ERASE, 23'h400000, 16'h0000);
        run(OP_READ, 23'h400011, 16'h0000);
        check("erased word", 16'hFFFF, got);
        run(OP_READ, 23'h600000, 16'h0000);
        check("spared word", 16'h5A5A, got);
    endtask
    // Guarded outer sectors ignore programs at both ends.
    task automatic t_guard();
        lock_guard_on = 1;
        run(OP_PROGRAM, 23'h000001, 16'h12A5);
        run(OP_READ, 23'h000001, 16'h0000);
        check("low guard", 16'hFFFF, got);
        run(OP_PROGRAM, 23'h7FF000, 16'h12A5);
        run(OP_READ, 23'h7FF000, 16'h0000);
        check("high guard", 16'hFFFF, got);
        lock_guard_on = 0;
    endtask
    // Hold and release flag, then reset, restore pulse and a read.
    task automatic t_hold_restore();
        run(OP_SUSPEND, 23'h400000, 16'h0000);
        check("held", 16'h0001, {15'h0, erase_held});
        run(OP_OTP_ENTER, 23'h000000, 16'h0000);
        run(OP_OTP_EXIT, 23'h000000, 16'h0000);
        run(OP_RESUME, 23'h400000, 16'h0000);
        check("resumed", 16'h0000, {15'h0, erase_held});
        run(OP_RESET, 23'h000000, 16'h0000);
        run(OP_RESTORE, 23'h000000, 16'h0000);
        run(OP_READ, 23'h600000, 16'h0000);
        check("after restore", 16'h5A5A, got);
    endtask
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1;
        repeat (3) @(posedge clock);
        t_program();
        t_bypass();
        t_erase();
        t_guard();
        t_hold_restore();
        test_done();
    end
endmodule
bind flash_host flash_host_monitor mon_u (
    .clock, .rst_n, .req_ready, .resp_valid, .op_busy, .lock_guard_on,
    .chip_sel_n, .write_n, .out_en_n, .restore_n, .lock_guard_n,
    .word_data_lines_oe, .addr_out, .word_data_lines_out);
